// [hdl/sram_addr_mux.sv]
// speech rom card address mux, decode and data gating
// Notes on behaviour
// RL1: 20-bit address sent over 8-bit bus
// RL2: upper portion latched on load-upper strobe
// RL3: middle portion latched in separate register
// RL4: controller loads upper, then middle, then low
// RL5: low address taken live from bus
// RL6: decode yields chip and write enables
// RL7: card enable only inside memory range
// RL8: row and column decode flag presence
// RL9: column enables outputs, row enables chips
// RL10: data driven only under data strobe
// RL11: 256 kbytes as virtual cards 0, 1
// RL12: card id from three-position switch
// RL13: clock, upper, middle, low, data select phases
// RL14: address registers clocked, held, reset-cleared
`timescale 1ns/1ps
module sram_addr_mux (
  input  wire logic                              mclk,
  input  wire logic                              rst_n,
  input  wire logic [sram_pkg::BUS_W-1:0]        bus_addr,
  input  wire sram_pkg::sram_strobe_t            strobe,
  input  wire logic [sram_pkg::ID_W-1:0]         card_id_sw,
  input  wire logic [sram_pkg::BUS_W-1:0]        mem_rdata,
  output logic      [sram_pkg::ADDR_W-1:0]       mem_addr,
  output sram_pkg::sram_decode_t                 dec,
  output logic                                   row_present,
  output logic                                   col_present,
  output logic      [sram_pkg::BUS_W-1:0]        data_out,
  output logic      [sram_pkg::BUS_W-1:0]        data_oe,
  output logic      [sram_pkg::ID_W-1:0]         card_id
);
  logic                          rst_s1_r;
  logic                          rst_s2_r;
  logic [sram_pkg::HI_W-1:0]     hi_r;
  logic [sram_pkg::HI_W-1:0]     hi_nxt;
  logic [sram_pkg::MID_W-1:0]    mid_r;
  logic [sram_pkg::MID_W-1:0]    mid_nxt;
  logic [sram_pkg::BUS_W-1:0]    dout_r;
  logic [sram_pkg::BUS_W-1:0]    dout_nxt;
  logic                          oe_r;
  logic                          oe_nxt;
  logic [sram_pkg::ID_W-1:0]     id_r;
  logic [sram_pkg::ID_W-1:0]     id_nxt;
  logic [sram_pkg::ROW_W-1:0]    row_sel;
  logic [sram_pkg::COL_W-1:0]    col_sel;
  logic                          in_range;
  logic [sram_pkg::ADDR_W-1:0]   offs;
  wire  [sram_pkg::NUM_DEV-1:0]  dev_chip_en;
  wire  [sram_pkg::NUM_DEV-1:0]  dev_out_en;
  wire  [sram_pkg::NUM_DEV-1:0]  dev_wr_en;

  // reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // address portion latches
  always_comb begin
    hi_nxt  = hi_r;
    mid_nxt = mid_r;
    if (strobe.ld_hi) begin
      hi_nxt = bus_addr[sram_pkg::HI_W-1:0]; // RL2
    end
    if (strobe.ld_mid) begin
      mid_nxt = bus_addr; // RL3
    end
  end

  always_ff @(posedge mclk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      hi_r  <= sram_pkg::HI_RST; // RL14
      mid_r <= sram_pkg::MID_RST; // RL14
    end else begin
      hi_r  <= hi_nxt; // RL14
      mid_r <= mid_nxt;
    end
  end

  // upper and middle held, low live from bus
  assign mem_addr = {hi_r, mid_r, bus_addr}; // RL1 RL5 RL13

  // decode
  assign offs     = mem_addr - sram_pkg::BASE_DEF;
  assign in_range = (offs < sram_pkg::MEM_BYTES); // RL7 RL11
  assign row_sel  = offs[sram_pkg::DEV_LSB+2:sram_pkg::DEV_LSB+1];
  assign col_sel  = {offs[sram_pkg::DEV_LSB], ~offs[sram_pkg::DEV_LSB]};

  // row pair picks the chips, column bit picks which outputs
  for (genvar k = 0; k < sram_pkg::NUM_DEV; k++) begin : g_dev
    localparam int ROW_IDX = k / 2;
    localparam int COL_IDX = k % 2;
    assign dev_chip_en[k] = in_range && (row_sel == ROW_IDX[sram_pkg::ROW_W-1:0]); // RL6 RL9
    assign dev_out_en[k]  = dev_chip_en[k] && col_sel[COL_IDX]; // RL9
    assign dev_wr_en[k]   = dev_out_en[k] && strobe.wr; // RL6

    property p_dev_slice;
      @(posedge mclk) disable iff (!rst_s2_r)
        dev_out_en[k] |-> offs[sram_pkg::DEV_LSB+2:sram_pkg::DEV_LSB] == {ROW_IDX[sram_pkg::ROW_W-1:0], COL_IDX[0]};
    endproperty
    a_dev_slice: assert property (p_dev_slice) else $error("device enabled outside its slice"); // RL9
  end

  always_comb begin
    dec.card_en = in_range; // RL7
    dec.vcard   = offs[sram_pkg::VCARD_BIT]; // RL11
    dec.chip_en = dev_chip_en; // RL6 RL9
    dec.out_en  = dev_out_en; // RL9
    dec.wr_en   = dev_wr_en; // RL6
  end

  assign row_present = in_range; // RL8
  assign col_present = in_range && (strobe.dsel || strobe.wr); // RL8

  // data gated by card enable and data strobe
  always_comb begin
    oe_nxt   = dec.card_en && strobe.dsel && !strobe.wr; // RL10
    dout_nxt = oe_nxt ? mem_rdata : '0; // RL10
    id_nxt   = card_id_sw; // RL12
  end

  always_ff @(posedge mclk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      oe_r   <= 1'b0;
      dout_r <= '0;
      id_r   <= '0;
    end else begin
      oe_r   <= oe_nxt;
      dout_r <= dout_nxt;
      id_r   <= id_nxt;
    end
  end

  assign data_out = dout_r;
  assign data_oe  = {sram_pkg::BUS_W{oe_r}};
  assign card_id  = id_r; // RL12

  property p_hi_load;
    @(posedge mclk) disable iff (!rst_s2_r) strobe.ld_hi |=> hi_r == $past(bus_addr[3:0]);
  endproperty
  a_hi_load: assert property (p_hi_load) else $error("upper address not latched"); // RL2

  property p_mid_load;
    @(posedge mclk) disable iff (!rst_s2_r) strobe.ld_mid |=> mid_r == $past(bus_addr);
  endproperty
  a_mid_load: assert property (p_mid_load) else $error("middle address not latched"); // RL3

  property p_hold;
    @(posedge mclk) disable iff (!rst_s2_r) !strobe.ld_hi && !strobe.ld_mid |=> $stable(hi_r) && $stable(mid_r);
  endproperty
  a_hold: assert property (p_hold) else $error("address register changed without strobe"); // RL14

  property p_low_live;
    @(posedge mclk) disable iff (!rst_s2_r) mem_addr[7:0] == bus_addr;
  endproperty
  a_low_live: assert property (p_low_live) else $error("low address not from bus"); // RL5

  property p_range;
    @(posedge mclk) disable iff (!rst_s2_r) dec.card_en == (mem_addr < 20'h40000);
  endproperty
  a_range: assert property (p_range) else $error("card enable outside range"); // RL7

  property p_chip_gate;
    @(posedge mclk) disable iff (!rst_s2_r) !dec.card_en |-> dec.chip_en == '0 && dec.wr_en == '0;
  endproperty
  a_chip_gate: assert property (p_chip_gate) else $error("chip enable without card enable"); // RL6

  property p_out_chip;
    @(posedge mclk) disable iff (!rst_s2_r) (dec.out_en & ~dec.chip_en) == '0;
  endproperty
  a_out_chip: assert property (p_out_chip) else $error("output enable without chip enable"); // RL9

  sequence s_read_req;
    dec.card_en && strobe.dsel && !strobe.wr;
  endsequence
  property p_data_gate;
    @(posedge mclk) disable iff (!rst_s2_r) s_read_req |=> data_oe[0] && data_out == $past(mem_rdata);
  endproperty
  a_data_gate: assert property (p_data_gate) else $error("read data not driven"); // RL10

  property p_no_strobe;
    @(posedge mclk) disable iff (!rst_s2_r) !strobe.dsel |=> !data_oe[0];
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("data driven without strobe"); // RL10

  sequence s_load_hi;
    strobe.ld_hi && !strobe.ld_mid;
  endsequence
  sequence s_load_mid;
    strobe.ld_mid && !strobe.ld_hi;
  endsequence

  property p_mid_keeps_hi;
    @(posedge mclk) disable iff (!rst_s2_r)
      s_load_mid |=> $stable(hi_r);
  endproperty
  a_mid_keeps_hi: assert property (p_mid_keeps_hi) else $error("upper address moved on middle load"); // RL3

  property p_hi_keeps_mid;
    @(posedge mclk) disable iff (!rst_s2_r)
      s_load_hi |=> $stable(mid_r);
  endproperty
  a_hi_keeps_mid: assert property (p_hi_keeps_mid) else $error("middle address moved on upper load"); // RL3

  property p_addr_assembly;
    @(posedge mclk) disable iff (!rst_s2_r)
      s_load_hi ##1 s_load_mid |=> mem_addr[sram_pkg::ADDR_W-1:sram_pkg::MID_LSB] ==
        {$past(bus_addr[sram_pkg::HI_W-1:0], 2), $past(bus_addr)};
  endproperty
  a_addr_assembly: assert property (p_addr_assembly) else $error("address portions not assembled"); // RL1 RL13

  property p_full_read;
    @(posedge mclk) disable iff (!rst_s2_r)
      s_load_hi ##1 s_load_mid ##1 s_read_req |=> data_oe[0] && data_out == $past(mem_rdata);
  endproperty
  a_full_read: assert property (p_full_read) else $error("phased read did not return data"); // RL13 RL10

  property p_chip_pair;
    @(posedge mclk) disable iff (!rst_s2_r)
      dec.card_en |-> $countones(dec.chip_en) == 2;
  endproperty
  a_chip_pair: assert property (p_chip_pair) else $error("row decode did not pick one pair"); // RL9

  property p_one_output;
    @(posedge mclk) disable iff (!rst_s2_r)
      dec.card_en |-> $onehot(dec.out_en);
  endproperty
  a_one_output: assert property (p_one_output) else $error("column decode did not pick one device"); // RL9

  property p_no_out_off;
    @(posedge mclk) disable iff (!rst_s2_r)
      !dec.card_en |-> dec.out_en == '0;
  endproperty
  a_no_out_off: assert property (p_no_out_off) else $error("outputs enabled outside range"); // RL7 RL9

  property p_row_flag;
    @(posedge mclk) disable iff (!rst_s2_r)
      row_present |-> dec.chip_en != '0;
  endproperty
  a_row_flag: assert property (p_row_flag) else $error("row flag without chip enable"); // RL8

  property p_col_flag;
    @(posedge mclk) disable iff (!rst_s2_r)
      !strobe.dsel && !strobe.wr |-> !col_present;
  endproperty
  a_col_flag: assert property (p_col_flag) else $error("column flag without access strobe"); // RL8

  property p_flags_off;
    @(posedge mclk) disable iff (!rst_s2_r)
      !dec.card_en |-> !row_present && !col_present;
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("presence flag outside range"); // RL8

  property p_wr_idle;
    @(posedge mclk) disable iff (!rst_s2_r)
      !strobe.wr |-> dec.wr_en == '0;
  endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("write enable without write"); // RL6

  property p_wr_pick;
    @(posedge mclk) disable iff (!rst_s2_r)
      strobe.wr && dec.card_en |-> dec.wr_en == dec.out_en;
  endproperty
  a_wr_pick: assert property (p_wr_pick) else $error("write enable on wrong device"); // RL6

  property p_wr_no_drive;
    @(posedge mclk) disable iff (!rst_s2_r)
      strobe.wr |=> !data_oe[0];
  endproperty
  a_wr_no_drive: assert property (p_wr_no_drive) else $error("data driven during write"); // RL10

  property p_range_no_drive;
    @(posedge mclk) disable iff (!rst_s2_r)
      !dec.card_en |=> !data_oe[0];
  endproperty
  a_range_no_drive: assert property (p_range_no_drive) else $error("data driven outside range"); // RL7 RL10

  property p_quiet_data;
    @(posedge mclk) disable iff (!rst_s2_r)
      !data_oe[0] |-> data_out == '0;
  endproperty
  a_quiet_data: assert property (p_quiet_data) else $error("data not cleared while idle"); // RL10

  property p_oe_all;
    @(posedge mclk) disable iff (!rst_s2_r)
      data_oe == '0 || data_oe == '1;
  endproperty
  a_oe_all: assert property (p_oe_all) else $error("data enables split"); // RL10

  property p_vcard;
    @(posedge mclk) disable iff (!rst_s2_r)
      dec.vcard == mem_addr[sram_pkg::VCARD_BIT];
  endproperty
  a_vcard: assert property (p_vcard) else $error("virtual card select wrong"); // RL11

  property p_card_id;
    @(posedge mclk) disable iff (!rst_s2_r)
      rst_s2_r |=> card_id == $past(card_id_sw);
  endproperty
  a_card_id: assert property (p_card_id) else $error("card number not taken from switch"); // RL12

  property p_range_top;
    @(posedge mclk) disable iff (!rst_s2_r)
      mem_addr[sram_pkg::ADDR_W-1:sram_pkg::VCARD_BIT+1] != '0 |-> !dec.card_en;
  endproperty
  a_range_top: assert property (p_range_top) else $error("card enabled above memory size"); // RL7 RL11

  property p_drop_after;
    @(posedge mclk) disable iff (!rst_s2_r)
      s_read_req ##1 !strobe.dsel |=> !data_oe[0];
  endproperty
  a_drop_after: assert property (p_drop_after) else $error("data held after strobe dropped"); // RL10

  property p_reset_clear;
    @(posedge mclk)
      !rst_s2_r |-> hi_r == sram_pkg::HI_RST && mid_r == sram_pkg::MID_RST && !data_oe[0];
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not cleared in reset"); // RL14
endmodule : sram_addr_mux

// [include/sram_pkg.sv]
// package for the speech rom card address mux
package sram_pkg;
  localparam int BUS_W      = 8;
  localparam int ADDR_W     = 20;
  localparam int HI_W       = 4;
  localparam int MID_W      = 8;
  localparam int LO_W       = 8;
  localparam int HI_LSB     = 16;
  localparam int MID_LSB    = 8;
  localparam int ROW_W      = 2;
  localparam int COL_W      = 2;
  localparam int NUM_DEV    = 8;
  localparam int ID_W       = 3;
  // 256 kbytes: addresses 0 .. 3ffff inside the card window
  localparam logic [ADDR_W-1:0] MEM_BYTES  = 20'h40000;
  localparam logic [ADDR_W-1:0] BASE_DEF   = 20'h00000;
  localparam logic [HI_W-1:0]   HI_RST     = 4'h0;
  localparam logic [MID_W-1:0]  MID_RST    = 8'h00;
  // device bank: 32 kbyte devices, row = addr[17:16], column = addr[15]
  localparam int DEV_LSB    = 15;
  localparam int VCARD_BIT  = 17;

  typedef struct packed {
    logic ld_hi;
    logic ld_mid;
    logic dsel;
    logic wr;
  } sram_strobe_t;

  typedef struct packed {
    logic               card_en;
    logic [NUM_DEV-1:0] chip_en;
    logic [NUM_DEV-1:0] wr_en;
    logic [NUM_DEV-1:0] out_en;
    logic               vcard;
  } sram_decode_t;
endpackage : sram_pkg

// [dv/sram_ctrl_model.sv]
// backplane controller model driving the address phases
`timescale 1ns/1ps
module sram_ctrl_model (
  input  wire logic                   mclk,
  output logic [sram_pkg::BUS_W-1:0]  bus_addr,
  output sram_pkg::sram_strobe_t      strobe
);
  initial begin
    bus_addr = 8'h00;
    strobe   = '0;
  end
  // upper then middle then low with select, or with write strobe for a write; junk in unused upper bits
  task automatic phases(input logic [19:0] a, input logic w);
    @(negedge mclk);
    bus_addr = {4'ha, a[19:16]};
    strobe   = 4'h8;
    @(negedge mclk);
    bus_addr = a[15:8];
    strobe   = 4'h4;
    @(negedge mclk);
    bus_addr = a[7:0];
    strobe   = w ? 4'h1 : 4'h2;
  endtask : phases
  task automatic mid_only(input logic [7:0] m);
    @(negedge mclk);
    bus_addr = m;
    strobe   = 4'h4;
    @(negedge mclk);
    strobe   = '0;
  endtask : mid_only
  // released bus shows the inverse of its last value
  task automatic idle();
    strobe   = '0;
    bus_addr = ~bus_addr;
  endtask : idle
endmodule : sram_ctrl_model

// [dv/tb.sv]
// self-checking bench for the speech rom address mux
`timescale 1ns/1ps
module tb;
  logic                   mclk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [2:0]             card_id_sw = 3'h0;
  logic [7:0]             mem_rdata, bus_addr, data_out, data_oe;
  logic [2:0]             card_id;
  logic [19:0]            mem_addr;
  logic                   row_present, col_present;
  sram_pkg::sram_strobe_t strobe;
  sram_pkg::sram_decode_t dec;
  int                     n_mismatch = 0;
  int                     comparisons = 0;
  always #4 mclk = ~mclk;
  assign mem_rdata = mem_addr[7:0] ^ 8'h5a;
  sram_ctrl_model ctl (.mclk(mclk), .bus_addr(bus_addr), .strobe(strobe));
  sram_addr_mux uut (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .strobe(strobe),
    .card_id_sw(card_id_sw), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .dec(dec),
    .row_present(row_present), .col_present(col_present), .data_out(data_out),
    .data_oe(data_oe), .card_id(card_id));
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic t_reset();
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk("hi_mid", 20'h0, mem_addr[19:8]);
    chk("data_oe", 20'h0, data_oe);
  endtask : t_reset
  task automatic t_card_id();
    card_id_sw = 3'h5;
    repeat (2) @(negedge mclk);
    chk("card_id", 20'h5, card_id);
  endtask : t_card_id
  task automatic t_access(input logic [19:0] a, input logic w);
    logic inr;
    logic drv;
    logic [7:0] dev;
    logic [7:0] pair;
    inr = a < sram_pkg::MEM_BYTES;
    drv = inr & ~w;
    dev = inr ? 8'h01 << a[17:15] : 8'h00;
    pair = inr ? 8'h03 << {a[17:16], 1'b0} : 8'h00;
    ctl.phases(a, w);
    #1;
    chk("mem_addr", a, mem_addr);
    chk("card_en", inr, dec.card_en);
    chk("vcard", a[17], dec.vcard);
    chk("row_present", inr, row_present);
    chk("col_present", inr, col_present);
    chk("out_en", dev, dec.out_en);
    chk("chip_en", pair, dec.chip_en);
    chk("wr_en", w ? dev : 8'h00, dec.wr_en);
    if (inr) chk("one_dev", 20'h1, $countones(dec.chip_en & dec.out_en));
    @(negedge mclk);
    ctl.idle();
    #1;
    chk("data_oe", drv ? 8'hff : 8'h00, data_oe);
    chk("data_out", drv ? a[7:0] ^ 8'h5a : 8'h00, data_out);
    @(negedge mclk);
    #1;
    chk("data_oe_off", 20'h0, data_oe);
  endtask : t_access
  task automatic t_mid_hold();
    ctl.mid_only(8'h3c);
    #1;
    chk("hi_kept", 20'h13c, mem_addr[19:8]);
  endtask : t_mid_hold
  task automatic t_reset_mid();
    @(negedge mclk);
    rst_n = 1'b0;
    #1;
    chk("hi_mid_clr", 20'h0, mem_addr[19:8]);
    chk("card_id_clr", 20'h0, card_id);
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk("card_id_back", 20'h5, card_id);
  endtask : t_reset_mid
  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
  initial begin
    t_reset();
    t_card_id();
    t_access(20'h00000, 1'b0);
    t_access(20'h3ffff, 1'b0);
    t_access(20'h1a5c3, 1'b0);
    t_mid_hold();
    t_reset_mid();
    t_access(20'h40000, 1'b0);
    t_access(20'hfffff, 1'b0);
    t_access(20'h28a01, 1'b1);
    test_done();
  end
endmodule : tb
